// file: verif/cgsc_bus_master.sv
// two-wire bus master model that writes the config bytes
module cgsc_bus_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen;
  // ==========================================================
  // line phases
  // idle: both lines left to the pull-ups
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
    ack_o = 1'b1;
  end
  // five cycles a phase so each edge clears the synchronisers
  task automatic ph();
    repeat (5) @(posedge clk_i);
  endtask
  // data set while clock low, then one clock pulse
  task automatic pulse(input logic pull);
    sda_pull_o <= pull;
    ph();
    scl_o <= 1'b1;
    ph();
    seen = sda_i;
    scl_o <= 1'b0;
    ph();
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_pull_o <= 1'b0;
    ph();
    scl_o <= 1'b1;
    ph();
    sda_pull_o <= 1'b1;
    ph();
    scl_o <= 1'b0;
    ph();
  endtask
  // n leading bits; a whole byte also takes the ninth pulse
  task automatic send(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--) pulse(!v[i]);
    if (n == 8) begin
      pulse(1'b0);
      ack_o <= seen;
    end
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_pull_o <= 1'b1;
    ph();
    scl_o <= 1'b1;
    ph();
    sda_pull_o <= 1'b0;
    ph();
  endtask
endmodule

// file: verif/cgsc_top_assertions.sv
// port checks for the serial config receiver
module cgsc_top_checker
  import cgsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic serial_clock_line_i,
  input wire logic serial_data_line_o,
  input wire logic serial_data_line_oe_o,
  input wire logic synth_proc_clk_i,
  input wire logic [NUM_PROC-1:0] processor_clock_outputs_o,
  input wire logic [NUM_BUS-1:0] bus_clock_outputs_o,
  input wire logic clock_outputs_oe_o,
  input wire logic spread_enable_o,
  input wire logic test_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // ==========================================================
  // checks
  // test-mode history: the divider switch-over is not compared
  logic [3:0] tm_q;
  always_ff @(posedge clk_i) begin
    tm_q <= {tm_q[2:0], test_mode_o};
  end
  data_pull_only_a: assert property (serial_data_line_oe_o |-> !serial_data_line_o)
    else $error("data line driven high");
  quiet_reset_a: assert property ($fell(srst_i) |-> processor_clock_outputs_o == '0
      && bus_clock_outputs_o == '0 && clock_outputs_oe_o && !serial_data_line_oe_o)
    else $error("outputs not quiet after reset");
  ack_clock_low_a: assert property ($rose(serial_data_line_oe_o) |-> !serial_clock_line_i)
    else $error("ack raised with clock high");
  ack_hold_a: assert property ($rose(serial_data_line_oe_o) |-> serial_data_line_oe_o[*3])
    else $error("ack too short");
  ack_release_a: assert property (serial_data_line_oe_o |-> ##[1:60] !serial_data_line_oe_o)
    else $error("ack never released");
  ack_gap_a: assert property ($fell(serial_data_line_oe_o) |-> !serial_data_line_oe_o[*8])
    else $error("ack inside a byte");
  mode_excl_a: assert property (!(spread_enable_o && test_mode_o))
    else $error("two modes at once");
  hiz_mode_a: assert property (!clock_outputs_oe_o |-> !spread_enable_o && !test_mode_o)
    else $error("three-state with another mode");
  proc_gate_a: assert property (tm_q == 4'h0 && !test_mode_o |->
      (processor_clock_outputs_o & ~{NUM_PROC{$past(synth_proc_clk_i, 3)}}) == '0)
    else $error("processor clock high without source");
  ack_c: cover property ($rose(serial_data_line_oe_o));
  test_c: cover property ($rose(test_mode_o));
  spread_c: cover property ($rose(spread_enable_o));
  hiz_c: cover property ($fell(clock_outputs_oe_o));
endmodule

bind cgsc_top cgsc_top_checker cgsc_top_checker_inst (
  .clk_i(clk_i), .srst_i(srst_i), .serial_clock_line_i(serial_clock_line_i),
  .serial_data_line_o(serial_data_line_o), .serial_data_line_oe_o(serial_data_line_oe_o),
  .synth_proc_clk_i(synth_proc_clk_i), .processor_clock_outputs_o(processor_clock_outputs_o),
  .bus_clock_outputs_o(bus_clock_outputs_o), .clock_outputs_oe_o(clock_outputs_oe_o),
  .spread_enable_o(spread_enable_o), .test_mode_o(test_mode_o)
);

// file: verif/cgsc_top_tb_top.sv
// self-checking bench for the serial config receiver
module cgsc_top_tb_top
  import cgsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // pins and bench state
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic xtal = 1'b1;
  logic [3:0] syn = 4'hF;
  logic [2:0] strap = 3'h0;
  logic smp = 1'b0;
  logic ak = 1'b1;
  wire scl, pull, m_ack, sda_o, sda_oe, apic, usb, io, coe, spr, tst;
  wire [3:0] proc;
  wire [6:0] bus;
  wire [11:0] mem;
  wire [1:0] refo;
  wire [2:0] fsel;
  wire sda = !(pull || (sda_oe && !sda_o));
  wire [34:0] obs = {m_ack, fsel, spr, tst, coe, proc, bus, mem, apic, refo, usb, io};
  wire [4:0] cur = {apic, bus[0], io, proc[0], usb};
  logic [7:0] cfg [7] = '{8'h00, 8'hCF, 8'h7F, 8'hFF, 8'h0F, 8'h13, 8'h00};
  logic [7:0] wmask [7] = '{8'h7B, 8'hCF, 8'h7F, 8'hFF, 8'h0F, 8'h13, 8'h00};
  logic [7:0] nxt [7];
  logic [34:0] q [$];
  logic [34:0] e, m;
  logic [4:0] pv;
  int cnt [5] = '{default: 0};
  int err_total = 0;
  int compares = 0;
  // 10 MHz clock
  always #50 clk_i = !clk_i;
  cgsc_top cgsc_top_inst (
    .clk_i(clk_i), .srst_i(srst_i), .serial_clock_line_i(scl), .serial_data_line_i(sda),
    .serial_data_line_o(sda_o), .serial_data_line_oe_o(sda_oe), .crystal_input_i(xtal),
    .synth_proc_clk_i(syn[0]), .synth_bus_clk_i(syn[1]), .synth_usb_clk_i(syn[2]),
    .synth_io_clk_i(syn[3]), .strap_freq_select_i(strap), .processor_clock_outputs_o(proc),
    .bus_clock_outputs_o(bus), .memory_clock_outputs_o(mem), .interrupt_controller_clock_o(apic),
    .crystal_copy_out_o(refo), .usb_peripheral_clock_o(usb), .io_peripheral_clock_o(io),
    .clock_outputs_oe_o(coe), .freq_select_o(fsel), .spread_enable_o(spr), .test_mode_o(tst)
  );
  cgsc_bus_master cgsc_bus_master_inst (
    .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull), .ack_o(m_ack)
  );
  // ==========================================================
  // checking
  task automatic check(input logic [34:0] got, input logic [34:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic near(input int c, input int x);
    return c >= x - 1 && c <= x + 1;
  endfunction
  // expected port picture with all sources held high
  function automatic logic [34:0] exp_v();
    logic [1:0] f;
    f = cfg[0][1:0];
    return {ak, cfg[0][3] ? cfg[0][6:4] : strap, f == 2'h2, f == 2'h1, f != 2'h3,
        cfg[1][3:0], cfg[2][6:0], cfg[4][3:0], cfg[3], cfg[5][4], cfg[5][1:0], cfg[1][7:6]};
  endfunction
  // note an expectation and ask the monitor for a sample
  task automatic want();
    q.push_back(exp_v());
    smp <= 1'b1;
    @(posedge clk_i);
    smp <= 1'b0;
  endtask
  // clock lanes are masked in test mode, their phase is free there
  always @(posedge clk_i) begin
    if (smp) begin
      e = q.pop_front();
      m = {7'h7F, {28{!e[29]}}};
      check(obs & m, e & m);
    end
  end
  // rising-edge counts per divider class
  always @(posedge clk_i) begin
    pv <= cur;
    for (int k = 0; k < 5; k++) cnt[k] <= cnt[k] + int'(!pv[k] && cur[k]);
  end
  // ==========================================================
  // stimulus
  task automatic fill();
    foreach (nxt[i]) nxt[i] = 8'($urandom) & wmask[i];
    nxt[0][1:0] = 2'h0;
  endtask
  // address, command, count, then nb data bits; no stop leaves a restart
  task automatic xfer(input logic [7:0] ad, input int nb, input logic fin);
    logic [7:0] mk;
    int n;
    cgsc_bus_master_inst.start();
    cgsc_bus_master_inst.send(ad, 8);
    ak = (ad != DEV_ADDR);
    cgsc_bus_master_inst.send(8'($urandom), 8);
    cgsc_bus_master_inst.send(8'($urandom), 8);
    for (int k = 0; k < nb; k += 8) begin
      n = (nb - k > 8) ? 8 : nb - k;
      cgsc_bus_master_inst.send(nxt[k / 8], n);
      mk = 8'hFF << (8 - n);
      if (!ak) cfg[k / 8] = (cfg[k / 8] & ~mk) | (nxt[k / 8] & mk);
      want();
    end
    if (fin) cgsc_bus_master_inst.stop();
  endtask
  initial begin
    int c0 [5];
    c0[0] = $urandom(32'h4177DBA1);
    strap <= 3'($urandom);
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    want();
    repeat (3) begin
      fill();
      xfer(DEV_ADDR, 56, 1'b1);
    end
    nxt = cfg;
    nxt[1] = 8'hCF;
    nxt[2] = 8'h7F;
    nxt[5] = 8'h13;
    for (int f = 0; f < 4; f++) begin
      nxt[0][1:0] = 2'(f);
      xfer(DEV_ADDR, 48, 1'b1);
      if (f == 1) begin
        c0 = cnt;
        repeat (64) begin
          repeat (4) @(posedge clk_i);
          xtal <= !xtal;
        end
        repeat (4) @(posedge clk_i);
        check(35'(near(cnt[0] - c0[0], 16) && near(cnt[2] - c0[2], 8)), 35'h1);
        check(35'(near(cnt[1] - c0[1], 16) && near(cnt[3] - c0[3], 8)), 35'h1);
        check(35'(near(cnt[4] - c0[4], 32)), 35'h1);
      end
    end
    fill();
    xfer(8'hD3, 56, 1'b1);
    fill();
    xfer(DEV_ADDR, 12, 1'b0);
    fill();
    xfer(DEV_ADDR, 19, 1'b1);
    fill();
    xfer(DEV_ADDR, 56, 1'b1);
    repeat (200) begin
      @(posedge clk_i);
      syn <= 4'($urandom);
      xtal <= 1'($urandom);
    end
    syn <= 4'hF;
    xtal <= 1'b1;
    repeat (6) @(posedge clk_i);
    want();
    stop_test();
  end
  // hang guard, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    stop_test();
  end
endmodule

// file: verilog/cgsc_pkg.sv
// constants for the serial configuration receiver of the clock generator
package cgsc_pkg;

  // ==========================================================
  // serial link
  localparam logic [7:0] DEV_ADDR = 8'hD2;
  localparam logic [3:0] BYTE_CMD = 4'h1;
  localparam logic [3:0] BYTE_CNT = 4'h2;
  localparam logic [3:0] BYTE_DATA0 = 4'h3;
  localparam logic [3:0] BYTE_LAST = 4'h9;
  localparam logic [3:0] BYTE_MAX = 4'hF;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int NUM_CFG = 7;

  // ==========================================================
  // configuration byte indices
  localparam logic [2:0] IDX_FREQ = 3'h0;
  localparam logic [2:0] IDX_PROC = 3'h1;
  localparam logic [2:0] IDX_BUS = 3'h2;
  localparam logic [2:0] IDX_MEM_LO = 3'h3;
  localparam logic [2:0] IDX_MEM_HI = 3'h4;
  localparam logic [2:0] IDX_REF = 3'h5;

  // ==========================================================
  // reset values and writable bits, byte 6 down to byte 0
  localparam logic [6:0][7:0] CFG_RST = {8'h00, 8'h13, 8'h0F, 8'hFF, 8'h7F, 8'hCF, 8'h00};
  localparam logic [6:0][7:0] CFG_MASK = {8'h00, 8'h13, 8'h0F, 8'hFF, 8'h7F, 8'hCF, 8'h7B};

  // ==========================================================
  // field positions
  localparam int FREQ_SEL_LSB = 4;
  localparam int FREQ_SRC_BIT = 3;
  localparam int FUNC_LSB = 0;
  localparam int USB_EN_BIT = 7;
  localparam int IO_EN_BIT = 6;
  localparam int BUS_FREE_BIT = 6;
  localparam int APIC_EN_BIT = 4;
  localparam int NUM_PROC = 4;
  localparam int NUM_BUS = 7;
  localparam int NUM_MEM = 12;
  localparam int NUM_OUT = 28;

  // ==========================================================
  // function field codes
  localparam logic [1:0] FUNC_NORMAL = 2'h0;
  localparam logic [1:0] FUNC_TEST = 2'h1;
  localparam logic [1:0] FUNC_SPREAD = 2'h2;
  localparam logic [1:0] FUNC_HIZ = 2'h3;

  // ==========================================================
  // strap capture delay after reset release, in cycles
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // synchroniser width: scl, sda, crystal, four synth clocks, three straps
  localparam int SYNC_W = 10;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_BYTE,
    ST_ACK,
    ST_IGNORE
  } cgsc_state_t;

endpackage

// file: verilog/cgsc_sync.sv
// two flip-flop synchroniser for a group of asynchronous inputs
module cgsc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // ==========================================================
  // one pair of flops per bit; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= async_i[gi];
          stab_q <= meta_q;
        end
      end
      assign sync_o[gi] = stab_q;
    end
  endgenerate

endmodule

// file: verilog/cgsc_top.sv
// serial configuration receiver and output gating of the clock generator
//
// How it works
// R01: enable bit one runs, zero holds low
// R02: byte one processor, byte two bus enables
// R03: bytes three and four enable memory clocks
// R04: byte five interrupt and reference enables
// R05: serial field picks frequency pair
// R06: serial field rules only when source bit set
// R07: function field picks normal, spread, three-state
// R08: test mode divides crystal for core clocks
// R09: test mode divides crystal for peripheral clocks
// R10: data line open drain, pull low only
// R11: never read back, acknowledge each byte
// R12: master keeps data steady while clock high
// R13: master frames write with start, stop
// R14: accept bits only after start and address
// R15: each bit acts on arrival, no shadow
// R16: unsent bits keep previous values
// R17: stop or repeated start ends the write
// R18: address byte is fixed, mismatch ignored
// R19: command and count bytes discarded
// R20: bits arrive most significant first
// R21: master writes zero to reserved bits
// R22: acknowledge low during ninth clock pulse
module cgsc_top
  import cgsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic serial_clock_line_i,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_o,
  input wire logic crystal_input_i,
  input wire logic synth_proc_clk_i,
  input wire logic synth_bus_clk_i,
  input wire logic synth_usb_clk_i,
  input wire logic synth_io_clk_i,
  input wire logic [2:0] strap_freq_select_i,
  output logic [NUM_PROC-1:0] processor_clock_outputs_o,
  output logic [NUM_BUS-1:0] bus_clock_outputs_o,
  output logic [NUM_MEM-1:0] memory_clock_outputs_o,
  output logic interrupt_controller_clock_o,
  output logic [1:0] crystal_copy_out_o,
  output logic usb_peripheral_clock_o,
  output logic io_peripheral_clock_o,
  output logic clock_outputs_oe_o,
  output logic [2:0] freq_select_o,
  output logic spread_enable_o,
  output logic test_mode_o
);

  // ==========================================================
  // input synchronisers
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic scl_s;
  logic sda_s;
  logic xtal_s;
  logic [2:0] strap_s;
  assign raw_in = {strap_freq_select_i, synth_io_clk_i, synth_usb_clk_i,
                   synth_bus_clk_i, synth_proc_clk_i, crystal_input_i,
                   serial_data_line_i, serial_clock_line_i};
  cgsc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i(raw_in),
    .sync_o(sync_in)
  );
  assign scl_s = sync_in[0];
  assign sda_s = sync_in[1];
  assign xtal_s = sync_in[2];
  assign strap_s = sync_in[9:7];

  // ==========================================================
  // line edges, taken from the settled stage only
  logic scl_prev_q;
  logic sda_prev_q;
  logic xtal_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      xtal_prev_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      xtal_prev_q <= xtal_s;
    end
  end
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  // data moving while clock stays high frames a transfer
  assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s; // R12
  assign stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s; // R12

  // ==========================================================
  // serial receiver state
  cgsc_state_t state_q;
  cgsc_state_t state_d;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [3:0] byte_q;
  logic [3:0] byte_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic done_q;
  logic done_d;
  logic ack_oe_q;
  logic ack_oe_d;
  logic [6:0][7:0] cfg_q;
  logic [6:0][7:0] cfg_d;
  logic [2:0] cfg_idx;
  logic [2:0] bit_pos;
  // data byte index and bit position of the bit last shifted in
  assign cfg_idx = 3'(byte_q - BYTE_DATA0);
  assign bit_pos = 3'(BIT_LAST - bit_q + 3'h1); // R20
  // next state of the receiver and the configuration bytes
  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    byte_d = byte_q;
    shift_d = shift_q;
    done_d = done_q;
    ack_oe_d = ack_oe_q;
    cfg_d = cfg_q;
    if (start_cond) begin
      // a repeated start closes the write and opens a new one
      state_d = ST_ADDR; // R14 R17
      bit_d = 3'h0;
      byte_d = 4'h0;
      done_d = 1'b0;
      ack_oe_d = 1'b0;
    end else if (stop_cond) begin
      state_d = ST_IDLE; // R13 R17
      bit_d = 3'h0;
      done_d = 1'b0;
      ack_oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          ack_oe_d = 1'b0;
        end
        ST_ADDR, ST_BYTE: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s}; // R20
            bit_d = 3'(bit_q + 3'h1);
            done_d = (bit_q == BIT_LAST);
          end else if (scl_fall && done_q) begin
            done_d = 1'b0;
            if (state_q == ST_ADDR && shift_q != DEV_ADDR) begin
              state_d = ST_IGNORE; // R18
            end else begin
              // command, count and extra bytes are acknowledged unused
              state_d = ST_ACK; // R11 R19
              ack_oe_d = 1'b1; // R22
              if (byte_q != BYTE_MAX) begin
                byte_d = 4'(byte_q + 4'h1);
              end
            end
          end
          // a bit lands as its pulse closes, so the rise ahead of a stop never writes
          if (scl_fall && state_q == ST_BYTE && byte_q >= BYTE_DATA0 &&
              byte_q <= BYTE_LAST) begin
            cfg_d[cfg_idx][bit_pos] = shift_q[0] & CFG_MASK[cfg_idx][bit_pos]; // R15 R16
          end
        end
        ST_ACK: begin
          // the fall that ends the ninth pulse releases the line
          if (scl_fall) begin
            ack_oe_d = 1'b0; // R22
            state_d = ST_BYTE;
            bit_d = 3'h0;
          end
        end
        ST_IGNORE: begin
          ack_oe_d = 1'b0; // R14
        end
        default: begin
          state_d = ST_IDLE;
          ack_oe_d = 1'b0;
        end
      endcase
    end
  end

  // receiver and configuration registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      bit_q <= 3'h0;
      byte_q <= 4'h0;
      shift_q <= 8'h00;
      done_q <= 1'b0;
      ack_oe_q <= 1'b0;
      cfg_q <= CFG_RST; // R01
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      shift_q <= shift_d;
      done_q <= done_d;
      ack_oe_q <= ack_oe_d;
      cfg_q <= cfg_d;
    end
  end

  // ==========================================================
  // strap sampling: loaded on the first three cycles after reset, the last after the synchroniser has settled
  logic [1:0] strap_wait_q;
  logic [1:0] strap_wait_d;
  logic [2:0] strap_q;
  logic [2:0] strap_d;
  always_comb begin
    strap_wait_d = strap_wait_q;
    strap_d = strap_q;
    if (strap_wait_q != STRAP_WAIT) begin
      strap_wait_d = 2'(strap_wait_q + 2'h1);
      strap_d = strap_s;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_wait_q <= 2'h0;
      strap_q <= 3'h0;
    end else begin
      strap_wait_q <= strap_wait_d;
      strap_q <= strap_d;
    end
  end

  // ==========================================================
  // crystal dividers for test mode
  logic div2_q;
  logic div2_d;
  logic div4_q;
  logic div4_d;
  // both toggle on crystal rising edges so they stay in phase
  always_comb begin
    div2_d = div2_q;
    div4_d = div4_q;
    if (xtal_s & ~xtal_prev_q) begin
      div2_d = ~div2_q; // R08 R09
      if (div2_q) begin
        div4_d = ~div4_q; // R08 R09
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div2_q <= 1'b0;
      div4_q <= 1'b0;
    end else begin
      div2_q <= div2_d;
      div4_q <= div4_d;
    end
  end

  // ==========================================================
  // mode decode
  logic [1:0] func;
  logic [2:0] freq_d;
  logic test_mode;
  assign func = cfg_q[IDX_FREQ][FUNC_LSB+1:FUNC_LSB];
  assign test_mode = (func == FUNC_TEST);
  // strap choice stands unless the source bit hands over to the field
  always_comb begin
    if (cfg_q[IDX_FREQ][FREQ_SRC_BIT]) begin
      freq_d = cfg_q[IDX_FREQ][FREQ_SEL_LSB+2:FREQ_SEL_LSB]; // R05 R06
    end else begin
      freq_d = strap_q; // R06
    end
  end

  // ==========================================================
  // per-output sources and enables
  logic [NUM_OUT-1:0] src_all;
  logic [NUM_OUT-1:0] en_all;
  logic [NUM_OUT-1:0] clk_d;
  logic [NUM_OUT-1:0] clk_q;
  logic proc_src;
  logic bus_src;
  logic usb_src;
  logic io_src;
  // test mode bypasses the synthesiser; the line is only as fine as
  // the sampling clock, so this is a functional model of the clocks
  always_comb begin
    if (test_mode) begin
      proc_src = div2_q; // R08
      bus_src = div4_q; // R08
      usb_src = div2_q; // R09
      io_src = div4_q; // R09
    end else begin
      proc_src = sync_in[3]; // R07
      bus_src = sync_in[4];
      usb_src = sync_in[5];
      io_src = sync_in[6];
    end
  end

  // vector order: proc, bus, mem, apic, ref, usb, io from bit 0 up
  always_comb begin
    src_all = {io_src, usb_src, {2{xtal_s}}, xtal_s,
               {NUM_MEM{proc_src}}, {NUM_BUS{bus_src}}, {NUM_PROC{proc_src}}}; // R07 R08
    en_all = {cfg_q[IDX_PROC][IO_EN_BIT], cfg_q[IDX_PROC][USB_EN_BIT],
              cfg_q[IDX_REF][1:0], cfg_q[IDX_REF][APIC_EN_BIT], // R04
              cfg_q[IDX_MEM_HI][3:0], cfg_q[IDX_MEM_LO], // R03
              cfg_q[IDX_BUS][BUS_FREE_BIT:0], // R02
              cfg_q[IDX_PROC][NUM_PROC-1:0]}; // R02
  end

  // a cleared enable holds its output low rather than floating it
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_gate
      assign clk_d[gi] = en_all[gi] & src_all[gi]; // R01
    end
  endgenerate

  // ==========================================================
  // output registers
  logic oe_q;
  logic [2:0] freq_q;
  logic spread_q;
  logic test_q;
  logic sda_out_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clk_q <= '0;
      oe_q <= 1'b1;
      freq_q <= 3'h0;
      spread_q <= 1'b0;
      test_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
      oe_q <= (func != FUNC_HIZ); // R07
      freq_q <= freq_d; // R05
      spread_q <= (func == FUNC_SPREAD); // R07
      test_q <= test_mode;
      sda_out_q <= 1'b0; // R10
    end
  end

  assign processor_clock_outputs_o = clk_q[3:0];
  assign bus_clock_outputs_o = clk_q[10:4];
  assign memory_clock_outputs_o = clk_q[22:11];
  assign interrupt_controller_clock_o = clk_q[23];
  assign crystal_copy_out_o = clk_q[25:24];
  assign usb_peripheral_clock_o = clk_q[26];
  assign io_peripheral_clock_o = clk_q[27];
  assign clock_outputs_oe_o = oe_q;
  assign freq_select_o = freq_q;
  assign spread_enable_o = spread_q;
  assign test_mode_o = test_q;
  // the line is only ever pulled low or let go
  assign serial_data_line_o = sda_out_q; // R10
  assign serial_data_line_oe_o = ack_oe_q; // R10 R11

endmodule
